/* logic/glmr_core.sv */
// load model rate selection, current classification, relax detection, qmax gating, run averages
// Summary of operation
// - load mode 0 selects constant current, 1 constant power; default 0
// - load mode bit is mirrored into a control status flag
// - current model selector 0..6 picks prev, present, filtered, slow, cap/5, host, user
// - selector resets to 1, present cycle average
// - power model selector 0..6 picks the matching power sources
// - selector 3 uses filtered current through a 14 s low pass filter
// - selector 4 uses design capacity or design energy over five
// - selector 5 uses host rate value, mA or 10 mW units
// - charge reserve left after reported charge hits zero, no-load compensated
// - energy reserve left after reported energy hits zero, no-load compensated
// - discharge only when magnitude exceeds discharge threshold
// - charge only when magnitude exceeds charge threshold
// - enter relax when filtered current below quit current for a relax time
// - after five minutes in relax, rest voltage readings are attempted
// - capacity update also needs voltage slope below 4 uV/s
// - leave relax after current above quit current for quit relax time
// - one chemical capacity per cell profile, learned from charge passed
// - update status bit 0 is set when new capacity is learned
// - average current per discharge cycle is stored as last run value
// - current times voltage averaged per discharge cycle as last run power
module glmr_core
  import glmr_pkg::*;
#(
  parameter int unsigned SEC_CYC = SEC_CYCLES  // cycles per second tick
) (
  input  wire logic               core_clk,          // 50 MHz gauge clock
  input  wire logic               sys_rst,           // synchronous reset, high
  input  wire glmr_cfg_t          cfg,               // configuration parameters
  input  wire glmr_meas_t         meas,              // measurements, same clock domain
  input  wire logic               profile_sel,       // active cell profile
  input  wire logic [15:0]        dq_passed,         // charge passed since last rest reading
  input  wire logic [15:0]        dsoc_pct,          // soc delta between rest readings, percent
  input  wire logic [7:0]         upd_status_wr,     // host write data for update status
  input  wire logic [NUM_PROFILES-1:0] upd_status_we, // host write strobes per profile
  output logic                    load_model_flag,   // mirrored load mode in status word
  output logic [15:0]             rate_out,          // selected compensation rate
  output logic [15:0]             reserve_charge,    // reserve below zero reported_charge_left
  output logic [15:0]             reserve_energy,    // reserve below zero reported_energy_left
  output logic                    reserve_noload,    // reserves use no-load compensation
  output logic                    is_discharge,      // discharge current flowing
  output logic                    is_charge,         // charge current flowing
  output logic                    relax,             // relaxation mode
  output logic                    ocv_take,          // pulse: take rest voltage reading
  output logic                    qmax_upd,          // pulse: chemical capacity updated
  output logic [15:0]             qmax [NUM_PROFILES], // chemical capacity per profile
  output logic [7:0]              upd_status [NUM_PROFILES], // per profile update status
  output logic signed [15:0]      avg_i_last_run,    // previous cycle average current
  output logic signed [15:0]      avg_p_last_run     // previous cycle average power, 10 mW
);
  glmr_state_t        state_reg;
  logic [25:0]        sec_cnt_reg;
  logic               sec_tick;
  logic [15:0]        dwell_reg;
  logic [15:0]        relax_secs_reg;
  logic               ocv_done_reg;
  logic [15:0]        abs_cur;
  logic [15:0]        abs_avg;
  logic signed [31:0] slow_reg;
  logic signed [47:0] i_acc_reg;
  logic signed [47:0] p_acc_reg;
  logic [31:0]        n_reg;
  logic signed [15:0] pres_i_reg;
  logic signed [15:0] pres_p_reg;
  logic signed [31:0] inst_p;
  logic signed [15:0] slow_i;
  logic [15:0]        cur_rate;
  logic [15:0]        pwr_rate;
  logic               dsg_now;

  always_ff @(posedge core_clk) begin
    if (sys_rst || sec_cnt_reg == 26'(SEC_CYC - 1)) sec_cnt_reg <= '0;
    else sec_cnt_reg <= sec_cnt_reg + 26'h1;
  end
  assign sec_tick = (sec_cnt_reg == 26'(SEC_CYC - 1));

  assign abs_cur = meas.current_ma[15] ? 16'(-meas.current_ma) : meas.current_ma;
  assign abs_avg = meas.filtered_current_reading[15] ?
                   16'(-meas.filtered_current_reading) : meas.filtered_current_reading;

  // threshold compare on magnitude keeps sense noise from flipping direction
  assign dsg_now = meas.current_ma[15] && abs_cur > cfg.dsg_threshold;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      is_discharge <= 1'b0;
      is_charge    <= 1'b0;
    end else if (meas.sample_stb) begin
      is_discharge <= dsg_now;
      is_charge    <= !meas.current_ma[15] && abs_cur > cfg.chg_threshold;
    end
  end

  // relax state machine; dwell counts whole seconds the entry or exit condition held
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg      <= GLMR_ACTIVE;
      dwell_reg      <= '0;
      relax_secs_reg <= '0;
    end else begin
      unique case (state_reg)
        GLMR_ACTIVE: begin
          relax_secs_reg <= '0;
          if (abs_avg >= cfg.quit_current) dwell_reg <= '0;
          else if (sec_tick) begin
            if (dwell_reg + 16'h1 >= cfg.dsg_relax_s ||
                dwell_reg + 16'h1 >= cfg.chg_relax_s) begin
              state_reg <= GLMR_RELAX;
              dwell_reg <= '0;
            end else dwell_reg <= dwell_reg + 16'h1;
          end
        end
        GLMR_RELAX: begin
          if (sec_tick && relax_secs_reg != 16'hFFFF) relax_secs_reg <= relax_secs_reg + 16'h1;
          if (abs_avg <= cfg.quit_current) dwell_reg <= '0;
          else if (sec_tick) begin
            if (dwell_reg + 16'h1 >= cfg.quit_relax_s) begin
              state_reg <= GLMR_ACTIVE;
              dwell_reg <= '0;
            end else dwell_reg <= dwell_reg + 16'h1;
          end
        end
      endcase
    end
  end
  assign relax = (state_reg == GLMR_RELAX);

  // one rest reading per relax period; a second would double-count the soc delta
  always_ff @(posedge core_clk) begin
    if (sys_rst || !relax) begin
      ocv_take     <= 1'b0;
      ocv_done_reg <= 1'b0;
    end else begin
      ocv_take <= !ocv_done_reg && relax_secs_reg >= 16'(OCV_WAIT_S);
      if (relax_secs_reg >= 16'(OCV_WAIT_S)) ocv_done_reg <= 1'b1;
    end
  end

  // learned flag: a device set beats a simultaneous host write
  for (genvar p = 0; p < NUM_PROFILES; p++) begin : g_prof
    logic learn;
    assign learn = ocv_take && !meas.slope_uv_s[15] &&
                   meas.slope_uv_s < 16'(SLOPE_MAX_UV_S) &&
                   profile_sel == 1'(p) && dsoc_pct != 16'h0;
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        qmax[p]       <= QMAX_RST;
        upd_status[p] <= UPD_STAT_RST;
      end else begin
        if (learn) qmax[p] <= 16'((32'(dq_passed) * 32'd100) / 32'(dsoc_pct));
        if (learn) upd_status[p] <= upd_status[p] | 8'h01;
        else if (upd_status_we[p]) upd_status[p] <= upd_status_wr & 8'h01;
      end
    end
  end
  assign qmax_upd = |{g_prof[1].learn, g_prof[0].learn};

  // per-cycle accumulators; power in 10 mW units from mA * mV / 10000
  assign inst_p = 32'(($signed(32'(meas.current_ma)) * $signed({16'h0, meas.voltage_mv}))
                      / 32'sd10000);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      i_acc_reg      <= '0;
      p_acc_reg      <= '0;
      n_reg          <= '0;
      avg_i_last_run <= AVG_I_LAST_RST;
      avg_p_last_run <= AVG_P_LAST_RST;
    end else if (meas.sample_stb) begin
      // classify the sample itself: the registered flag lags one sample and
      // would drop the first discharge sample and count the first idle one
      if (dsg_now) begin
        i_acc_reg <= i_acc_reg + 48'(meas.current_ma);
        p_acc_reg <= p_acc_reg + 48'(inst_p);
        n_reg     <= n_reg + 32'h1;
      end else if (n_reg != 0) begin
        avg_i_last_run <= 16'(i_acc_reg / $signed({16'h0, n_reg}));
        avg_p_last_run <= 16'(p_acc_reg / $signed({16'h0, n_reg}));
        i_acc_reg      <= '0;
        p_acc_reg      <= '0;
        n_reg          <= '0;
      end
    end
  end
  assign pres_i_reg = (n_reg == 0) ? 16'h0 : 16'(i_acc_reg / $signed({16'h0, n_reg}));
  assign pres_p_reg = (n_reg == 0) ? 16'h0 : 16'(p_acc_reg / $signed({16'h0, n_reg}));

  // first order filter, alpha = 1/tau per second, state kept with 8 fraction bits
  always_ff @(posedge core_clk) begin
    if (sys_rst) slow_reg <= '0;
    else if (sec_tick)
      slow_reg <= slow_reg + (($signed({meas.filtered_current_reading, 8'h00}) - slow_reg)
                  / 32'sd14);
  end
  assign slow_i = 16'(slow_reg >>> 8);

  always_comb begin
    unique case (cfg.load_sel)
      SEL_PREV_AVG:  cur_rate = avg_i_last_run;
      SEL_PRES_AVG:  cur_rate = pres_i_reg;
      SEL_FILTERED:  cur_rate = meas.filtered_current_reading;
      SEL_SLOW_FILT: cur_rate = slow_i;
      SEL_DESIGN_5:  cur_rate = cfg.design_capacity / 16'd5;
      SEL_HOST_RATE: cur_rate = cfg.host_rate_value;
      SEL_USER_RATE: cur_rate = cfg.user_current_rate;
      default:       cur_rate = pres_i_reg;
    endcase
  end
  always_comb begin
    unique case (cfg.load_sel)
      SEL_PREV_AVG:  pwr_rate = avg_p_last_run;
      SEL_PRES_AVG:  pwr_rate = pres_p_reg;
      SEL_FILTERED:  pwr_rate = 16'(32'($signed(meas.filtered_current_reading) *
                                $signed({16'h0, meas.voltage_mv})) / 32'sd10000);
      SEL_SLOW_FILT: pwr_rate = 16'(32'($signed(slow_i) *
                                $signed({16'h0, meas.voltage_mv})) / 32'sd10000);
      SEL_DESIGN_5:  pwr_rate = cfg.design_energy / 16'd5;
      SEL_HOST_RATE: pwr_rate = cfg.host_rate_value;
      SEL_USER_RATE: pwr_rate = cfg.user_power_rate;
      default:       pwr_rate = pres_p_reg;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      load_model_flag <= LOAD_MODE_RST;
      rate_out        <= '0;
      reserve_charge  <= '0;
      reserve_energy  <= '0;
      reserve_noload  <= 1'b0;
    end else begin
      load_model_flag <= cfg.load_mode;
      rate_out        <= cfg.load_mode ? pwr_rate : cur_rate;
      reserve_charge  <= cfg.reserve_mah;
      reserve_energy  <= cfg.reserve_mwh;
      reserve_noload  <= 1'b1;
    end
  end

  mode_flag_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    load_model_flag == $past(cfg.load_mode)) else $error("load flag not mirrored");
  mode_sel_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    cfg.load_mode && cfg.load_sel == SEL_USER_RATE |=> rate_out == $past(cfg.user_power_rate))
    else $error("power user rate not selected");
  cur_sel_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !cfg.load_mode && cfg.load_sel == SEL_HOST_RATE |=> rate_out == $past(cfg.host_rate_value))
    else $error("host rate not selected");
  design_div_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !cfg.load_mode && cfg.load_sel == SEL_DESIGN_5 |=> rate_out == $past(cfg.design_capacity) / 5)
    else $error("design fifth wrong");
  dsg_class_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    meas.sample_stb && !meas.current_ma[15] |=> !is_discharge)
    else $error("positive current classed discharge");
  chg_class_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    meas.sample_stb && abs_cur <= cfg.chg_threshold |=> !is_charge)
    else $error("charge below threshold");
  relax_entry_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(relax) |-> $past(abs_avg < cfg.quit_current))
    else $error("relax entered with high current");
  relax_exit_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(relax) |-> $past(abs_avg > cfg.quit_current))
    else $error("relax left with low current");
  ocv_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    ocv_take |-> relax && relax_secs_reg >= 16'(OCV_WAIT_S))
    else $error("rest reading too early");
  learn_flag_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    g_prof[0].learn |=> upd_status[0][0]) else $error("learned flag not set");
  slope_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    qmax_upd |-> !meas.slope_uv_s[15] && meas.slope_uv_s < 4)
    else $error("capacity learned on steep slope");
  relax_cov: cover property (@(posedge core_clk) $rose(relax));
  ocv_cov: cover property (@(posedge core_clk) ocv_take);
  learn_cov: cover property (@(posedge core_clk) qmax_upd);
  run_cov: cover property (@(posedge core_clk) $changed(avg_i_last_run));
endmodule : glmr_core

/* logic/glmr_pkg.sv */
// package of constants and carrier types for the gauge load model and relax logic
package glmr_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned SLOPE_MAX_UV_S  = 4;
  localparam int unsigned LPF_TAU_S       = 14;
  localparam int unsigned OCV_WAIT_S      = 300;
  localparam int unsigned SEC_CYCLES      = CLK_HZ;
  localparam logic [2:0]  SEL_PREV_AVG    = 3'h0;
  localparam logic [2:0]  SEL_PRES_AVG    = 3'h1;
  localparam logic [2:0]  SEL_FILTERED    = 3'h2;
  localparam logic [2:0]  SEL_SLOW_FILT   = 3'h3;
  localparam logic [2:0]  SEL_DESIGN_5    = 3'h4;
  localparam logic [2:0]  SEL_HOST_RATE   = 3'h5;
  localparam logic [2:0]  SEL_USER_RATE   = 3'h6;
  localparam logic [2:0]  LOAD_SEL_RST    = 3'h1;
  localparam logic        LOAD_MODE_RST   = 1'b0;
  localparam logic [15:0] AVG_I_LAST_RST  = 16'hFED4;
  localparam logic [15:0] AVG_P_LAST_RST  = 16'hFB50;
  localparam logic [15:0] QMAX_RST        = 16'h03E8;
  localparam logic [7:0]  UPD_STAT_RST    = 8'h00;
  localparam int unsigned UPD_LEARNED_BIT = 0;
  localparam int unsigned NUM_PROFILES    = 2;

  typedef enum logic [1:0] {GLMR_ACTIVE, GLMR_RELAX} glmr_state_t;

  typedef struct packed {
    logic        load_mode;
    logic [2:0]  load_sel;
    logic [15:0] host_rate_value;
    logic [15:0] user_current_rate;
    logic [15:0] user_power_rate;
    logic [15:0] design_capacity;
    logic [15:0] design_energy;
    logic [15:0] dsg_threshold;
    logic [15:0] chg_threshold;
    logic [15:0] quit_current;
    logic [15:0] dsg_relax_s;
    logic [15:0] chg_relax_s;
    logic [15:0] quit_relax_s;
    logic [15:0] reserve_mah;
    logic [15:0] reserve_mwh;
  } glmr_cfg_t;

  typedef struct packed {
    logic signed [15:0] current_ma;
    logic signed [15:0] filtered_current_reading;
    logic        [15:0] voltage_mv;
    logic signed [15:0] slope_uv_s;
    logic               sample_stb;
  } glmr_meas_t;
endpackage : glmr_pkg

/* verification/glmr_host_model.sv */
// host side model: measurement feed and golden-image writes of update status
module glmr_host_model
  import glmr_pkg::*;
(
  input  wire logic               core_clk, // gauge clock
  output glmr_meas_t              meas,     // measurement feed
  output logic [7:0]              upd_wr,   // update status write data
  output logic [NUM_PROFILES-1:0] upd_we    // update status write strobes
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    meas = '0;
    meas.voltage_mv = 16'h0E74;
    upd_wr = 8'h00;
    upd_we = '0;
  end
  task automatic level(input logic signed [15:0] filt, input logic signed [15:0] slope);
    @(posedge core_clk);
    #2;
    meas.filtered_current_reading = filt;
    meas.slope_uv_s = slope;
  endtask : level
  task automatic sample(input logic signed [15:0] cur);
    @(posedge core_clk);
    #2;
    meas.current_ma = cur;
    meas.sample_stb = 1'b1;
    @(posedge core_clk);
    #2;
    meas.sample_stb = 1'b0;
  endtask : sample
  // the host side touches the learned flag only when a golden image is prepared
  task automatic golden(input int p, input logic [7:0] v);
    @(posedge core_clk);
    #2;
    upd_wr = v;
    upd_we[p] = 1'b1;
    @(posedge core_clk);
    #2;
    upd_we = '0;
  endtask : golden
endmodule : glmr_host_model

/* verification/tb_glmr_core.sv */
// self-checking bench for the load model and relax logic
module tb_glmr_core import glmr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned SEC = 20; // short second so relax periods fit the run
  logic                    core_clk = 1'b0;
  logic                    sys_rst  = 1'b1;
  glmr_cfg_t               cfg;
  glmr_meas_t              meas;
  logic [7:0]              upd_wr;
  logic [NUM_PROFILES-1:0] upd_we;
  logic                    load_model_flag, reserve_noload, is_discharge, is_charge;
  logic                    relax, ocv_take, qmax_upd;
  logic [15:0]             rate_out, reserve_charge, reserve_energy;
  logic [15:0]             qmax [NUM_PROFILES];
  logic [7:0]              upd_status [NUM_PROFILES];
  logic signed [15:0]      avg_i_last_run, avg_p_last_run;
  int                      mismatches = 0;
  int                      n_checks = 0;
  logic [3:0]  tsel [10] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'hA, 4'hC, 4'hD, 4'hE};
  logic [15:0] texp [10] = '{16'h0000, 16'h01F4, 16'h00C8, 16'h0123, 16'h0456,
                             16'h0000, 16'h00B9, 16'h02E4, 16'h0123, 16'h0789};
  logic signed [15:0] ccur [4] = '{-16'sd51, -16'sd50, 16'sd41, 16'sd40};
  logic [1:0]  cexp [4] = '{2'b10, 2'b00, 2'b01, 2'b00};

  always #10 core_clk = ~core_clk;

  glmr_host_model glmr_host_model_inst (.core_clk(core_clk), .meas(meas), .upd_wr(upd_wr),
    .upd_we(upd_we));
  glmr_core #(.SEC_CYC(SEC)) glmr_core_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .cfg(cfg), .meas(meas), .profile_sel(1'b0), .dq_passed(16'h0258), .dsoc_pct(16'h0032),
    .upd_status_wr(upd_wr), .upd_status_we(upd_we), .load_model_flag(load_model_flag),
    .rate_out(rate_out), .reserve_charge(reserve_charge), .reserve_energy(reserve_energy),
    .reserve_noload(reserve_noload), .is_discharge(is_discharge), .is_charge(is_charge),
    .relax(relax), .ocv_take(ocv_take), .qmax_upd(qmax_upd), .qmax(qmax),
    .upd_status(upd_status), .avg_i_last_run(avg_i_last_run), .avg_p_last_run(avg_p_last_run));

  task automatic results;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask : chk

  // waits for relax high (0), a rest reading pulse (1) or relax low (2) inside [lo,hi]
  task automatic wt(input int s, input int lo, input int hi);
    int   n;
    logic v;
    n = 0;
    v = 1'b0;
    while (!v && n < hi) begin
      @(posedge core_clk);
      #2;
      n++;
      case (s)
        0: v = (relax === 1'b1);
        1: v = (ocv_take === 1'b1);
        default: v = (relax === 1'b0);
      endcase
    end
    if (!v) begin
      mismatches++;
      results();
    end
    chk(16'(n >= lo), 16'h0001);
  endtask : wt

  task automatic relax_run(input logic signed [15:0] slope, input logic [15:0] q,
                           input logic [7:0] st);
    glmr_host_model_inst.level(16'sd5, slope);
    wt(0, 40, 90);
    wt(1, 5970, 6030);
    @(posedge core_clk);
    #2;
    chk(qmax[0], q);
    chk(16'(upd_status[0]), 16'(st));
    chk(qmax[1], 16'h03E8);
    glmr_host_model_inst.level(16'sd100, slope);
    wt(2, 20, 65);
  endtask : relax_run

  initial begin
    cfg = '0;
    cfg.load_sel = 3'h1;
    cfg.host_rate_value = 16'h0123;
    cfg.user_current_rate = 16'h0456;
    cfg.user_power_rate = 16'h0789;
    cfg.design_capacity = 16'h03E8;
    cfg.design_energy = 16'h0E74;
    cfg.dsg_threshold = 16'h0032;
    cfg.chg_threshold = 16'h0028;
    cfg.quit_current = 16'h0014;
    cfg.dsg_relax_s = 16'h0003;
    cfg.chg_relax_s = 16'h0005;
    cfg.quit_relax_s = 16'h0002;
    cfg.reserve_mah = 16'h0064;
    cfg.reserve_mwh = 16'h0170;
    repeat (16) @(posedge core_clk);
    #2;
    sys_rst = 1'b0;
    glmr_host_model_inst.level(16'sd500, 16'sd10);
    repeat (2) @(posedge core_clk);
    #2;
    chk(16'(load_model_flag), 16'h0000);
    chk(rate_out, 16'h0000);
    chk(avg_i_last_run, 16'hFED4);
    chk(avg_p_last_run, 16'hFB50);
    chk(reserve_charge, 16'h0064);
    chk(reserve_energy, 16'h0170);
    chk(16'(reserve_noload), 16'h0001);
    for (int i = 0; i < 10; i++) begin
      cfg.load_mode = tsel[i][3];
      cfg.load_sel = tsel[i][2:0];
      repeat (2) @(posedge core_clk);
      #2;
      chk(rate_out, texp[i]);
      chk(16'(load_model_flag), 16'(tsel[i][3]));
    end
    for (int i = 0; i < 4; i++) begin
      glmr_host_model_inst.sample(ccur[i]);
      chk(16'({is_discharge, is_charge}), 16'(cexp[i]));
    end
    repeat (4) glmr_host_model_inst.sample(-16'sd200);
    repeat (2) glmr_host_model_inst.sample(16'sd0);
    repeat (3) @(posedge core_clk);
    #2;
    chk(avg_i_last_run, 16'hFF38);
    chk(avg_p_last_run, 16'hFFB6);
    cfg.load_mode = 1'b0;
    cfg.load_sel = 3'h0;
    repeat (2) @(posedge core_clk);
    #2;
    chk(rate_out, 16'hFF38);
    cfg.load_mode = 1'b1;
    repeat (2) @(posedge core_clk);
    #2;
    chk(rate_out, 16'hFFB6);
    cfg.load_mode = 1'b0;
    relax_run(16'sd10, 16'h03E8, 8'h00);
    relax_run(16'sd2, 16'h04B0, 8'h01);
    glmr_host_model_inst.golden(1, 8'hFF);
    @(posedge core_clk);
    #2;
    chk(16'(upd_status[1]), 16'h0001);
    results();
  end
endmodule : tb_glmr_core
